// ### logic/wbs_pkg.sv
// Package with register map, field layout and timing constants
package wbs_pkg;

    // ------------------------------------------------------------------
    // Register map (7-bit addresses)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_SECOND_LIN_FAULT = 7'h45;
    localparam logic [6:0] ADDR_WAKE_SRC_A       = 7'h46;
    localparam logic [6:0] ADDR_WAKE_SRC_B       = 7'h47;
    localparam logic [6:0] ADDR_INPUT_LEVEL      = 7'h48;

    localparam logic [7:0] RESET_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FAULT_LSB     = 1;
    localparam int FAULT_MSB     = 2;
    localparam int DEV_STRAP_BIT = 7;
    localparam int CFG_PULL_BIT  = 6;
    localparam int GP2_BIT       = 5;
    localparam int GP1_BIT       = 4;
    localparam int TIMER_BIT     = 4;

    // Valid bit masks; everything else is reserved and reads zero
    localparam logic [7:0] MASK_FAULT  = 8'h06;
    localparam logic [7:0] MASK_WAKE_A = 8'hf7;
    localparam logic [7:0] MASK_WAKE_B = 8'h30;
    localparam logic [7:0] MASK_LEVEL  = 8'hf7;

    // ------------------------------------------------------------------
    // Fault codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FAULT_NONE    = 2'b00,
        FAULT_THERMAL = 2'b01,
        FAULT_TX_DOM  = 2'b10,
        FAULT_BUS_DOM = 2'b11
    } wbs_fault_e;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ        = 64'd50_000_000;
    localparam longint DOM_TIMEOUT_US = 64'd20_000;
    localparam longint DOM_CYCLES    = (DOM_TIMEOUT_US * CLK_HZ) / 64'd1_000_000;
    localparam int     TXEN_TIME_NS  = 10_000;
    localparam int     TXEN_CYCLES   = (TXEN_TIME_NS + 19) / 20;
    localparam int     CNT_W         = 20;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic second_lin_wake;
        logic first_lin_wake;
        logic can_wake;
        logic timer_wake;
        logic [2:0] wake_pin;
        logic [1:0] gp_pin;
    } wbs_wake_s;

    typedef struct packed {
        logic tx_in;
        logic bus_dominant;
        logic thermal_shutdown;
        logic wake_capable;
        logic tx_off;
    } wbs_lin_s;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [2:0] csn_sync;
        logic [1:0] mosi_sync;
        logic [15:0] shift;
        logic [4:0] bit_cnt;
        logic [7:0] rd_data;
        logic [7:0] miso_data;
    } wbs_spi_s;

endpackage

// ### logic/wbs_lin_fault.sv
// Second LIN fault detector: dominant timeouts, thermal, tx re-enable
`timescale 1ns/1ps
module wbs_lin_fault #(
    parameter longint DOM_LIMIT = wbs_pkg::DOM_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire wbs_pkg::wbs_lin_s      lin,
    output logic [1:0]                  fault_now,
    output logic                        fault_event,
    output logic                        tx_enable
);

    typedef struct packed {
        logic [wbs_pkg::CNT_W-1:0] tx_cnt;
        logic [wbs_pkg::CNT_W-1:0] bus_cnt;
        logic [15:0]               en_cnt;
        logic [1:0]                code;
        logic                      tx_en;
    } wbs_lf_s;

    wbs_lf_s st_reg;
    wbs_lf_s st_next;

    logic idle;
    logic [wbs_pkg::CNT_W-1:0] lim;

    assign idle = lin.wake_capable | lin.tx_off;
    assign lim  = wbs_pkg::CNT_W'(DOM_LIMIT);

    always_comb begin
        st_next = st_reg;
        // Tx input low counts; high or idle clears
        if (lin.tx_in || idle) begin
            st_next.tx_cnt = '0;
        end else if (st_reg.tx_cnt <= lim) begin
            st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
        end
        // Bus dominance counts; recessive or idle clears
        if (!lin.bus_dominant || idle) begin
            st_next.bus_cnt = '0;
        end else if (st_reg.bus_cnt <= lim) begin
            st_next.bus_cnt = st_reg.bus_cnt + 1'b1;
        end
        if (st_reg.bus_cnt > lim) begin
            st_next.code = wbs_pkg::FAULT_BUS_DOM;
        end else if (st_reg.tx_cnt > lim) begin
            st_next.code = wbs_pkg::FAULT_TX_DOM;
        end else if (lin.thermal_shutdown) begin
            st_next.code = wbs_pkg::FAULT_THERMAL;
        end else begin
            st_next.code = wbs_pkg::FAULT_NONE;
        end
        // Re-enable only after tx high for enable time
        if (st_reg.code != wbs_pkg::FAULT_NONE || !lin.tx_in) begin
            st_next.en_cnt = '0;
            if (st_reg.code != wbs_pkg::FAULT_NONE) begin
                st_next.tx_en = 1'b0;
            end
        end else if (!st_reg.tx_en) begin
            if (st_reg.en_cnt >= 16'(wbs_pkg::TXEN_CYCLES - 1)) begin
                st_next.tx_en = 1'b1;
            end else begin
                st_next.en_cnt = st_reg.en_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '{default: '0, tx_en: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign fault_now   = st_reg.code;
    assign fault_event = st_reg.code != wbs_pkg::FAULT_NONE;
    assign tx_enable   = st_reg.tx_en;

    AST_TX_BLOCKED: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        st_reg.code != wbs_pkg::FAULT_NONE |=> !tx_enable)
        else $error("transmit enabled during fault");

    AST_TX_CLEAR: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (lin.tx_in || idle) |=> st_reg.tx_cnt == '0)
        else $error("tx timeout not ended");

    AST_BUS_CLEAR: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (!lin.bus_dominant || idle) |=> st_reg.bus_cnt == '0)
        else $error("bus timeout not ended");

    AST_BUS_CODE: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        st_reg.bus_cnt > lim |=> st_reg.code == wbs_pkg::FAULT_BUS_DOM)
        else $error("bus dominant code missing");

endmodule

// ### logic/wbs_status_regs.sv
// Wake and second-LIN status register bank behind a serial interface
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
module wbs_status_regs #(
    // Dominant timeout in clocks, 20 ms at the system clock
    parameter longint DOM_LIMIT = wbs_pkg::DOM_CYCLES
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                restart,
    // Serial register port
    input  wire logic                spi_sclk,
    input  wire logic                spi_csn,
    input  wire logic                spi_mosi,
    output logic                     spi_miso,
    // Wake events and fail-safe exit
    input  wire wbs_pkg::wbs_wake_s  wake_evt,
    input  wire logic                failsafe_exit,
    input  wire wbs_pkg::wbs_wake_s  failsafe_src,
    // Second LIN transceiver status
    input  wire wbs_pkg::wbs_lin_s   second_lin,
    output logic                     second_lin_tx_enable,
    // Supplies
    input  wire logic                highside_supply_ok,
    input  wire logic                can_supply_ok,
    output logic                     lin_supply_low,
    output logic                     can_supply_low,
    // Pin levels and modes
    input  wire logic [2:0]          wake_pin_in,
    input  wire logic [2:0]          wake_pin_cyclic,
    input  wire logic [2:0]          wake_pin_sample,
    input  wire logic [1:0]          gp_pin_in,
    input  wire logic [1:0]          gp_pin_selected,
    input  wire logic [1:0]          gp_pin_in_use,
    input  wire logic                normal_or_stop,
    input  wire logic                fail_output_test_pin,
    input  wire logic                interrupt_pullup_config
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        wbs_pkg::wbs_spi_s spi;
        logic [7:0]        second_lin_fault_status;
        logic [7:0]        wake_source_status_a;
        logic [7:0]        wake_source_status_b;
        logic [7:0]        input_level_status;
        logic [7:0]        rd_snap;
        logic [1:0]        rd_which;
        logic [2:0]        wk_s1;
        logic [2:0]        wk_s2;
        logic [1:0]        gp_s1;
        logic [1:0]        gp_s2;
        logic [1:0]        strap_s;
        logic              strap_done;
        logic              miso;
    } wbs_top_s;

    wbs_top_s st_reg;
    wbs_top_s st_next;

    logic [1:0] lin_fault_now;
    logic       lin_fault_evt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Maps address to register index; 4 means unmapped
    function automatic logic [2:0] reg_index(input logic [6:0] addr);
        unique case (addr)
            wbs_pkg::ADDR_SECOND_LIN_FAULT: reg_index = 3'd0;
            wbs_pkg::ADDR_WAKE_SRC_A:       reg_index = 3'd1;
            wbs_pkg::ADDR_WAKE_SRC_B:       reg_index = 3'd2;
            wbs_pkg::ADDR_INPUT_LEVEL:      reg_index = 3'd3;
            default:                        reg_index = 3'd4;
        endcase
    endfunction

    function automatic logic [7:0] wake_a(input wbs_pkg::wbs_wake_s w);
        wake_a = {w.second_lin_wake, w.first_lin_wake, w.can_wake,
                  w.timer_wake, 1'b0, w.wake_pin};
    endfunction

    // ------------------------------------------------------------------
    // Fault detector
    // ------------------------------------------------------------------
    wbs_lin_fault #(.DOM_LIMIT(DOM_LIMIT)) u_fault (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .lin         (second_lin),
        .fault_now   (lin_fault_now),
        .fault_event (lin_fault_evt),
        .tx_enable   (second_lin_tx_enable)
    );

    // Supply comparators are live: low ends with the threshold
    assign lin_supply_low = !highside_supply_ok;
    assign can_supply_low = !can_supply_ok;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_active;
    logic       cs_end;
    logic [2:0] idx;
    logic [7:0] wake_set_a;
    logic [7:0] wake_set_b;
    logic [7:0] clr;

    always_comb begin
        st_next   = st_reg;
        sclk_rise = st_reg.spi.sclk_sync[2:1] == 2'b01;
        sclk_fall = st_reg.spi.sclk_sync[2:1] == 2'b10;
        cs_active = !st_reg.spi.csn_sync[1];
        cs_end    = st_reg.spi.csn_sync[2:1] == 2'b01;
        idx       = reg_index(st_reg.spi.shift[6:0]);
        clr       = '0;
        // Two-stage synchronisers on all serial pins
        st_next.spi.sclk_sync = {st_reg.spi.sclk_sync[1:0], spi_sclk};
        st_next.spi.csn_sync  = {st_reg.spi.csn_sync[1:0], spi_csn};
        st_next.spi.mosi_sync = {st_reg.spi.mosi_sync[0], spi_mosi};
        st_next.wk_s1   = wake_pin_in;
        st_next.wk_s2   = st_reg.wk_s1;
        st_next.gp_s1   = gp_pin_in;
        st_next.gp_s2   = st_reg.gp_s1;
        st_next.strap_s = {st_reg.strap_s[0], fail_output_test_pin};

        // Serial frame: one unused bit, 7-bit address, then 8 data bits out
        if (!cs_active) begin
            st_next.spi.bit_cnt = '0;
        end else if (sclk_rise) begin
            st_next.spi.shift   = {st_reg.spi.shift[14:0],
                                   st_reg.spi.mosi_sync[1]};
            st_next.spi.bit_cnt = st_reg.spi.bit_cnt + 5'd1;
        end
        if (cs_active && sclk_fall) begin
            if (st_reg.spi.bit_cnt == 5'd8) begin
                // Snapshot at address end, so later events are kept
                unique case (idx)
                    3'd0: st_next.rd_snap = st_reg.second_lin_fault_status;
                    3'd1: st_next.rd_snap = st_reg.wake_source_status_a;
                    3'd2: st_next.rd_snap = st_reg.wake_source_status_b;
                    3'd3: st_next.rd_snap = st_reg.input_level_status;
                    default: st_next.rd_snap = '0;
                endcase
                st_next.rd_which = idx[1:0];
                if (idx[2]) begin
                    st_next.rd_which = 2'd3;
                end
                st_next.spi.miso_data = st_next.rd_snap;
            end else begin
                st_next.spi.miso_data = {st_reg.spi.miso_data[6:0], 1'b0};
            end
            st_next.miso = st_next.spi.miso_data[7];
        end
        // Clear only bits the host actually got, at frame end
        if (cs_end && st_reg.spi.bit_cnt >= 5'd16) begin
            clr = st_reg.rd_snap;
        end

        wake_set_a = wake_a(wake_evt);
        wake_set_b = '0;
        wake_set_b[wbs_pkg::GP2_BIT] = wake_evt.gp_pin[1];
        wake_set_b[wbs_pkg::GP1_BIT] = wake_evt.gp_pin[0];
        if (failsafe_exit) begin
            wake_set_a = wake_set_a | wake_a(failsafe_src);
            wake_set_b[wbs_pkg::GP2_BIT] |= failsafe_src.gp_pin[1];
            wake_set_b[wbs_pkg::GP1_BIT] |= failsafe_src.gp_pin[0];
        end

        // Set wins over clear; reserved bits masked
        if (st_reg.rd_which == 2'd1) begin
            st_next.wake_source_status_a =
                ((st_reg.wake_source_status_a & ~clr) | wake_set_a)
                & wbs_pkg::MASK_WAKE_A;
        end else begin
            st_next.wake_source_status_a =
                (st_reg.wake_source_status_a | wake_set_a)
                & wbs_pkg::MASK_WAKE_A;
        end
        if (st_reg.rd_which == 2'd2) begin
            st_next.wake_source_status_b =
                ((st_reg.wake_source_status_b & ~clr) | wake_set_b)
                & wbs_pkg::MASK_WAKE_B;
        end else begin
            st_next.wake_source_status_b =
                (st_reg.wake_source_status_b | wake_set_b)
                & wbs_pkg::MASK_WAKE_B;
        end

        // Fault code latches; cleared by read unless still active
        if (lin_fault_evt) begin
            st_next.second_lin_fault_status =
                {5'b0, lin_fault_now, 1'b0};
        end else if (st_reg.rd_which == 2'd0 && clr != '0) begin
            st_next.second_lin_fault_status = wbs_pkg::RESET_ZERO;
        end

        // Strap and config caught once after reset
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            st_next.input_level_status[wbs_pkg::DEV_STRAP_BIT] =
                st_reg.strap_s[1];
            st_next.input_level_status[wbs_pkg::CFG_PULL_BIT] =
                interrupt_pullup_config;
        end
        // Wake pins: live, or latest sample in cyclic mode
        for (int i = 0; i < 3; i++) begin
            if (!wake_pin_cyclic[i] || wake_pin_sample[i]) begin
                st_next.input_level_status[i] = st_reg.wk_s2[i];
            end
        end
        // Gp pins: no cyclic path at all
        for (int j = 0; j < 2; j++) begin
            if (gp_pin_selected[j] && gp_pin_in_use[j] && normal_or_stop) begin
                st_next.input_level_status[wbs_pkg::GP1_BIT + j] =
                    st_reg.gp_s2[j];
            end
        end
        st_next.input_level_status = st_next.input_level_status
                                     & wbs_pkg::MASK_LEVEL;

        // Restart: fault bits kept, rest zero
        if (restart) begin
            st_next.second_lin_fault_status =
                st_reg.second_lin_fault_status & wbs_pkg::MASK_FAULT;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg          <= '0;
            st_reg.spi.sclk_sync <= '0;
            st_reg.spi.csn_sync  <= 3'b111;
            st_reg.rd_which <= 2'd3;
            // Strap sync keeps running so the capture sees the pin
            st_reg.strap_s  <= st_next.strap_s;
        end else begin
            st_reg <= st_next;
        end
    end

    assign spi_miso = st_reg.miso;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_RSVD_ZERO: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        ((st_reg.wake_source_status_a & ~wbs_pkg::MASK_WAKE_A) == '0) &&
        ((st_reg.wake_source_status_b & ~wbs_pkg::MASK_WAKE_B) == '0) &&
        ((st_reg.second_lin_fault_status & ~wbs_pkg::MASK_FAULT) == '0))
        else $error("reserved bit set");

    AST_WAKE_SET: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        wake_evt.timer_wake && !restart
        |=> st_reg.wake_source_status_a[wbs_pkg::TIMER_BIT])
        else $error("timer wake flag lost");

    AST_FS_SET: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        failsafe_exit && failsafe_src.gp_pin[1]
        |=> st_reg.wake_source_status_b[wbs_pkg::GP2_BIT])
        else $error("fail-safe wake source not flagged");

    AST_FAULT_CODE: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        lin_fault_evt && !restart |=>
        st_reg.second_lin_fault_status[wbs_pkg::FAULT_MSB:wbs_pkg::FAULT_LSB]
        == $past(lin_fault_now))
        else $error("fault code mismatch");

    AST_RESTART_KEEP: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        restart && !lin_fault_evt |=> st_reg.second_lin_fault_status ==
        $past(st_reg.second_lin_fault_status))
        else $error("restart changed fault bits");

    AST_GP_HOLD: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        !gp_pin_selected[0] |=>
        $stable(st_reg.input_level_status[wbs_pkg::GP1_BIT]))
        else $error("gp level changed while unselected");

endmodule

// ### bench/wbs_host.sv
// Host serial master model that reads the status register bank
`timescale 1ns/1ps
module wbs_host (
    input  wire logic ref_clk,
    output logic      spi_sclk,
    output logic      spi_csn,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_csn  = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask

    // Frame of nrise clock rises; fewer than 16 aborts the read
    task automatic xfer(input logic [6:0] addr, input int nrise,
                        output logic [7:0] data);
        logic [15:0] word;
        word = {1'b0, addr, 8'h00};
        data = 8'h00;
        @(negedge ref_clk);
        spi_csn = 1'b0;
        for (int i = 15; i > 15 - nrise; i--) begin
            spi_mosi = word[i];
            half();
            spi_sclk = 1'b1;
            half();
            // Sampled late in the high phase, long after the last fall
            if (i < 8) data[i] = spi_miso;
            spi_sclk = 1'b0;
        end
        half();
        spi_csn = 1'b1;
        // Released line must not keep showing the last bit
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// ### bench/tb.sv
// Self-checking testbench for the wake and bus status register bank
`timescale 1ns/1ps
module tb;
    logic               ref_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               restart = 1'b0;
    logic               spi_sclk, spi_csn, spi_mosi, spi_miso;
    wbs_pkg::wbs_wake_s wake_evt = '0;
    wbs_pkg::wbs_wake_s fs_src = '0;
    logic               fs_exit = 1'b0;
    wbs_pkg::wbs_lin_s  lin = 5'b10000;
    logic               tx_en, lin_low, can_low;
    logic               hs_ok = 1'b1;
    logic               can_ok = 1'b1;
    logic [2:0]         wk_in = 3'b101;
    logic [2:0]         wk_cyc = 3'b000;
    logic [2:0]         wk_smp = 3'b000;
    logic [1:0]         gp_in = 2'b10;
    logic [1:0]         gp_sel = 2'b11;
    logic [1:0]         gp_use = 2'b11;
    logic               nos = 1'b1;
    logic               strap = 1'b1;
    logic               pull = 1'b1;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    logic [7:0]         d;

    always #10 ref_clk = ~ref_clk;

    // Short dominant timeout keeps the run brief
    wbs_status_regs #(.DOM_LIMIT(64)) dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .restart(restart), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .wake_evt(wake_evt),
        .failsafe_exit(fs_exit), .failsafe_src(fs_src), .second_lin(lin),
        .second_lin_tx_enable(tx_en), .highside_supply_ok(hs_ok),
        .can_supply_ok(can_ok), .lin_supply_low(lin_low),
        .can_supply_low(can_low), .wake_pin_in(wk_in),
        .wake_pin_cyclic(wk_cyc), .wake_pin_sample(wk_smp),
        .gp_pin_in(gp_in), .gp_pin_selected(gp_sel),
        .gp_pin_in_use(gp_use), .normal_or_stop(nos),
        .fail_output_test_pin(strap), .interrupt_pullup_config(pull));

    wbs_host host (.ref_clk(ref_clk), .spi_sclk(spi_sclk),
        .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    // ------------------------------------------------------------------
    // Checking and access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Index n counts from the fault register; 11 is unmapped
    task automatic rd(input int n, input logic [7:0] exp);
        host.xfer(wbs_pkg::ADDR_SECOND_LIN_FAULT + 7'(n), 16, d);
        chk(d, exp);
    endtask

    task automatic pulse(input logic [8:0] v);
        @(negedge ref_clk);
        wake_evt = v;
        @(negedge ref_clk);
        wake_evt = '0;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic conclude();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        rd(0, 8'h00);
        rd(1, 8'h00);
        rd(2, 8'h00);
        rd(11, 8'h00);
        rd(3, 8'he5);
        $display("test reset_values done");
        for (int i = 0; i < 9; i++) begin
            pulse(9'h001 << i);
            rd(1, i < 2 ? 8'h00 : 8'h01 << (i < 5 ? i - 2 : i - 1));
            rd(2, i < 2 ? 8'h10 << i : 8'h00);
        end
        pulse(9'h1ff);
        host.xfer(wbs_pkg::ADDR_WAKE_SRC_A, 12, d);
        rd(1, 8'hf7);
        rd(2, 8'h30);
        rd(1, 8'h00);
        fs_src = 9'h102;
        fs_exit = 1'b1;
        @(negedge ref_clk);
        fs_exit = 1'b0;
        rd(1, 8'h80);
        rd(2, 8'h20);
        $display("test wake_flags done");
        lin = 5'b10100;
        repeat (10) @(negedge ref_clk);
        rd(0, 8'h02);
        chk({7'h00, tx_en}, 8'h00);
        // Host holds its transmit input high to re-enable sending
        lin = 5'b10000;
        repeat (450) @(negedge ref_clk);
        chk({7'h00, tx_en}, 8'h00);
        repeat (100) @(negedge ref_clk);
        chk({7'h00, tx_en}, 8'h01);
        rd(0, 8'h02);
        rd(0, 8'h00);
        lin = 5'b10100;
        repeat (5) @(negedge ref_clk);
        lin = 5'b10000;
        repeat (3) @(negedge ref_clk);
        restart = 1'b1;
        @(negedge ref_clk);
        restart = 1'b0;
        rd(0, 8'h02);
        lin = 5'b11000;
        repeat (80) @(negedge ref_clk);
        rd(0, 8'h06);
        lin = 5'b11010;
        repeat (4) @(negedge ref_clk);
        rd(0, 8'h06);
        lin = 5'b00000;
        repeat (80) @(negedge ref_clk);
        rd(0, 8'h04);
        lin = 5'b10000;
        repeat (4) @(negedge ref_clk);
        rd(0, 8'h04);
        rd(0, 8'h00);
        $display("test lin_fault done");
        for (int k = 0; k < 4; k++) begin
            {hs_ok, can_ok} = 2'(k);
            @(negedge ref_clk);
            chk({6'h00, lin_low, can_low}, {6'h00, ~2'(k)});
        end
        $display("test supplies done");
        wk_cyc = 3'b111;
        wk_in = 3'b010;
        gp_in = 2'b01;
        repeat (10) @(negedge ref_clk);
        rd(3, 8'hd5);
        wk_smp = 3'b111;
        @(negedge ref_clk);
        wk_smp = 3'b000;
        repeat (6) @(negedge ref_clk);
        rd(3, 8'hd2);
        gp_sel = 2'b10;
        gp_in = 2'b10;
        repeat (10) @(negedge ref_clk);
        rd(3, 8'hf2);
        $display("test levels done");
        pulse(9'h1ff);
        lin = 5'b10100;
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b1;
        lin = 5'b10000;
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        rd(0, 8'h00);
        rd(1, 8'h00);
        $display("test second_reset done");
        conclude();
    end
endmodule
